// >>> verilog/baud_defines.vh
// Register map, field positions, reset values and prescale counts of the bit-rate generator
`ifndef BAUD_DEFINES_VH
`define BAUD_DEFINES_VH

// Register byte offsets on the AXI4-Lite bus
`define OFS_DIVISOR_LOW      5'h00
`define OFS_DIVISOR_HIGH     5'h04
`define OFS_BAUD_CONTROL     5'h08
`define OFS_TRANSMIT_CONTROL 5'h0c
`define OFS_BAUD_STATUS      5'h10
`define OFS_BAUD_COUNT       5'h14
`define OFS_TICK_COUNT       5'h18
`define ADDR_BITS            5

// Field positions
`define BIT_WIDE_DIVISOR     3
`define BIT_SYNC_MODE        4
`define BIT_HIGH_SPEED       2

// Reset values
`define RST_DIVISOR_LOW      8'h00
`define RST_DIVISOR_HIGH     8'h00
`define RST_BAUD_CONTROL     8'h00
`define RST_TRANSMIT_CONTROL 8'h00

// Prescale factors, in system clock cycles per divisor step
`define PRESCALE_64          7'h40
`define PRESCALE_16          7'h10
`define PRESCALE_4           7'h04

// AXI responses
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// >>> verilog/baud_prescaler.v
// Prescale counter: one pulse every prescale_len system clocks
`timescale 1ns/1ps
module baud_prescaler (
  input  wire       aclk,         // System clock
  input  wire       aresetn,      // Synchronous reset, active low
  input  wire       clear,        // Restart the count
  input  wire [6:0] prescale_len, // Cycles per pulse
  output reg        pre_tick      // One-cycle pulse
);

  reg  [6:0] pre_cnt_ff;
  wire [6:0] pre_last;

  assign pre_last = prescale_len - 7'd1;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_cnt_ff <= 7'd0;
      pre_tick   <= 1'b0;
    end
    else if (clear)
    begin
      pre_cnt_ff <= 7'd0;
      pre_tick   <= 1'b0;
    end
    else if (pre_cnt_ff >= pre_last)
    begin
      // Compare with >= so a shorter prescale after a mode change cannot overrun
      pre_cnt_ff <= 7'd0;
      pre_tick   <= 1'b1;
    end
    else
    begin
      pre_cnt_ff <= pre_cnt_ff + 7'd1;
      pre_tick   <= 1'b0;
    end
  end

endmodule // baud_prescaler

// >>> verilog/baud_rate_generator.v
// Bit-rate generator of a serial port with AXI4-Lite register access
`timescale 1ns/1ps
`include "baud_defines.vh"
module baud_rate_generator (
  input  wire        aclk,          // System clock, 100 MHz
  input  wire        aresetn,       // Synchronous reset, active low
  input  wire [4:0]  s_axi_awaddr,  // Write address
  input  wire [2:0]  s_axi_awprot,  // Write protection, unused
  input  wire        s_axi_awvalid, // Write address valid
  output reg         s_axi_awready, // Write address ready
  input  wire [31:0] s_axi_wdata,   // Write data
  input  wire [3:0]  s_axi_wstrb,   // Write byte strobes
  input  wire        s_axi_wvalid,  // Write data valid
  output reg         s_axi_wready,  // Write data ready
  output reg  [1:0]  s_axi_bresp,   // Write response
  output reg         s_axi_bvalid,  // Write response valid
  input  wire        s_axi_bready,  // Write response ready
  input  wire [4:0]  s_axi_araddr,  // Read address
  input  wire [2:0]  s_axi_arprot,  // Read protection, unused
  input  wire        s_axi_arvalid, // Read address valid
  output reg         s_axi_arready, // Read address ready
  output reg  [31:0] s_axi_rdata,   // Read data
  output reg  [1:0]  s_axi_rresp,   // Read response
  output reg         s_axi_rvalid,  // Read data valid
  input  wire        s_axi_rready,  // Read data ready
  output reg         baud_tick      // One pulse per bit period
);

  // Software registers
  reg  [7:0]  baud_divisor_low_ff;
  reg  [7:0]  baud_divisor_high_ff;
  reg  [7:0]  baud_control_ff;
  reg  [7:0]  transmit_control_ff;

  // Generator state
  reg  [15:0] brg_cnt_ff;
  reg  [15:0] tick_total_ff;

  // Write channel state
  reg         aw_got_ff;
  reg         w_got_ff;
  reg  [4:0]  aw_addr_ff;
  reg  [31:0] w_data_ff;
  reg  [3:0]  w_strb_ff;

  // Read channel state
  reg  [4:0]  ar_addr_ff;

  // Decoded mode and divisor
  wire        wide_divisor_select;
  wire        high_speed_select;
  wire        sync_mode_select;
  wire [15:0] baud_divisor_value;
  reg  [6:0]  prescale_len;
  wire        pre_tick;

  // Write decode
  wire        wr_fire;
  wire        wr_lane0;
  wire        wr_low;
  wire        wr_high;
  wire        wr_ctrl;
  wire        wr_txctl;
  wire        wr_mapped;
  wire        divisor_wr;

  // Read decode
  reg  [31:0] rd_word;
  reg         rd_mapped;

  assign wide_divisor_select = baud_control_ff[`BIT_WIDE_DIVISOR];
  assign high_speed_select   = transmit_control_ff[`BIT_HIGH_SPEED];
  assign sync_mode_select    = transmit_control_ff[`BIT_SYNC_MODE];

  // High byte joins the divisor only in 16-bit width
  assign baud_divisor_value = wide_divisor_select ?
                              {baud_divisor_high_ff, baud_divisor_low_ff} :
                              {8'h00, baud_divisor_low_ff};

  // Prescale factor per mode
  always @*
  begin
    prescale_len = `PRESCALE_64;
    case ({sync_mode_select, wide_divisor_select, high_speed_select})
      3'b000:  prescale_len = `PRESCALE_64;
      3'b001:  prescale_len = `PRESCALE_16;
      3'b010:  prescale_len = `PRESCALE_16;
      3'b011:  prescale_len = `PRESCALE_4;
      3'b100:  prescale_len = `PRESCALE_4;
      3'b101:  prescale_len = `PRESCALE_4;
      3'b110:  prescale_len = `PRESCALE_4;
      3'b111:  prescale_len = `PRESCALE_4;
      default: prescale_len = `PRESCALE_64;
    endcase
  end

  // Write happens once both address and data are held
  assign wr_fire   = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign wr_lane0  = w_strb_ff[0];
  assign wr_low    = wr_fire && (aw_addr_ff == `OFS_DIVISOR_LOW);
  assign wr_high   = wr_fire && (aw_addr_ff == `OFS_DIVISOR_HIGH);
  assign wr_ctrl   = wr_fire && (aw_addr_ff == `OFS_BAUD_CONTROL);
  assign wr_txctl  = wr_fire && (aw_addr_ff == `OFS_TRANSMIT_CONTROL);
  assign wr_mapped = wr_low || wr_high || wr_ctrl || wr_txctl ||
                     (aw_addr_ff == `OFS_BAUD_STATUS) ||
                     (aw_addr_ff == `OFS_BAUD_COUNT) ||
                     (aw_addr_ff == `OFS_TICK_COUNT);

  // A divisor write restarts both counter stages
  assign divisor_wr = (wr_low || wr_high) && wr_lane0;

  baud_prescaler u_prescaler (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .clear        (divisor_wr),
    .prescale_len (prescale_len),
    .pre_tick     (pre_tick)
  );

  // Write address and data channels, taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      aw_addr_ff    <= 5'd0;
      w_data_ff     <= 32'h0000_0000;
      w_strb_ff     <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_got_ff && !s_axi_awready && !s_axi_bvalid)
      begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[4:2], 2'b00};
      end
      if (s_axi_wvalid && !w_got_ff && !s_axi_wready && !s_axi_bvalid)
      begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register storage, byte lane 0 only
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      baud_divisor_low_ff  <= `RST_DIVISOR_LOW;
      baud_divisor_high_ff <= `RST_DIVISOR_HIGH;
      baud_control_ff      <= `RST_BAUD_CONTROL;
      transmit_control_ff  <= `RST_TRANSMIT_CONTROL;
    end
    else if (wr_lane0)
    begin
      if (wr_low)
      begin
        baud_divisor_low_ff <= w_data_ff[7:0];
      end
      if (wr_high)
      begin
        baud_divisor_high_ff <= w_data_ff[7:0];
      end
      if (wr_ctrl)
      begin
        baud_control_ff <= w_data_ff[7:0] & 8'h08;
      end
      if (wr_txctl)
      begin
        transmit_control_ff <= w_data_ff[7:0] & 8'h14;
      end
    end
  end

  // Divisor stage: counts prescale pulses from 0 to n
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      brg_cnt_ff    <= 16'h0000;
      baud_tick     <= 1'b0;
      tick_total_ff <= 16'h0000;
    end
    else if (divisor_wr)
    begin
      brg_cnt_ff <= 16'h0000;
      baud_tick  <= 1'b0;
    end
    else if (pre_tick)
    begin
      // >= keeps the period bounded when n shrinks mid-count
      if (brg_cnt_ff >= baud_divisor_value)
      begin
        brg_cnt_ff    <= 16'h0000;
        baud_tick     <= 1'b1;
        tick_total_ff <= tick_total_ff + 16'h0001;
      end
      else
      begin
        brg_cnt_ff <= brg_cnt_ff + 16'h0001;
        baud_tick  <= 1'b0;
      end
    end
    else
    begin
      baud_tick <= 1'b0;
    end
  end

  // Read decode
  always @*
  begin
    rd_word   = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (ar_addr_ff)
      `OFS_DIVISOR_LOW:      rd_word = {24'h00_0000, baud_divisor_low_ff};
      `OFS_DIVISOR_HIGH:     rd_word = {24'h00_0000, baud_divisor_high_ff};
      `OFS_BAUD_CONTROL:     rd_word = {24'h00_0000, baud_control_ff};
      `OFS_TRANSMIT_CONTROL: rd_word = {24'h00_0000, transmit_control_ff};
      `OFS_BAUD_STATUS:      rd_word = {9'h000, prescale_len, baud_divisor_value};
      `OFS_BAUD_COUNT:       rd_word = {16'h0000, brg_cnt_ff};
      `OFS_TICK_COUNT:       rd_word = {16'h0000, tick_total_ff};
      default:
      begin
        rd_word   = 32'h0000_0000;
        rd_mapped = 1'b0;
      end
    endcase
  end

  // Read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      ar_addr_ff    <= 5'd0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
      begin
        s_axi_arready <= 1'b1;
        ar_addr_ff    <= {s_axi_araddr[4:2], 2'b00};
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // baud_rate_generator

// >>> verif/baud_checker_asserts.sv
// Checker of bus handshakes and tick spacing of the bit-rate generator
`timescale 1ns/1ps
module baud_checker (
  input wire logic        aclk,          // Clock
  input wire logic        aresetn,       // Reset
  input wire logic [4:0]  s_axi_awaddr,  // Write addr
  input wire logic        s_axi_awready, // Write addr ready
  input wire logic        s_axi_wready,  // Write data ready
  input wire logic [3:0]  s_axi_wstrb,   // Strobes
  input wire logic [1:0]  s_axi_bresp,   // Write resp
  input wire logic        s_axi_bvalid,  // Write resp valid
  input wire logic        s_axi_bready,  // Write resp ready
  input wire logic [4:0]  s_axi_araddr,  // Read addr
  input wire logic        s_axi_arvalid, // Read addr valid
  input wire logic        s_axi_arready, // Read addr ready
  input wire logic [31:0] s_axi_rdata,   // Read data
  input wire logic        s_axi_rvalid,  // Read valid
  input wire logic        s_axi_rready,  // Read ready
  input wire logic        baud_tick      // Bit tick
);
  logic [4:0] wa_ff;
  logic       ws_ff;
  logic [4:0] ra_ff;
  always @(posedge aclk)
  begin
    if (s_axi_awready) wa_ff <= s_axi_awaddr;
    if (s_axi_wready) ws_ff <= s_axi_wstrb[0];
    if (s_axi_arready) ra_ff <= s_axi_araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_tick_gap; baud_tick |=> !baud_tick [*3]; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too soon");
  property p_restart; $rose(s_axi_bvalid) && ws_ff && wa_ff < 5'h08 |=> !baud_tick [*4]; endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready long");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read late");
  property p_rd_upper; s_axi_rvalid && ra_ff < 5'h10 |-> s_axi_rdata[31:8] == 24'h00_0000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
  property p_wr_okay; s_axi_bvalid && wa_ff < 5'h1c |-> s_axi_bresp == 2'h0; endproperty
  a_wr_okay: assert property (p_wr_okay) else $error("bad bresp");
endmodule // baud_checker
bind baud_rate_generator baud_checker baud_checker_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awready,
  .s_axi_wready, .s_axi_wstrb, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .baud_tick);

// >>> verif/tb.sv
// Self-checking bench of the bit-rate generator
`timescale 1ns/1ps
module tb;
  logic        aclk = 0, aresetn = 0, baud_tick;
  logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [16:0] seed;
  int          fail_count = 0, num_checks = 0, lo, hi, wide, sync, hs, k, per;
  baud_rate_generator baud_rate_generator_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .baud_tick);
  always #5 aclk = ~aclk;
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  function automatic int pre();
    return sync ? 4 : wide ? (hs ? 4 : 16) : (hs ? 16 : 64);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    n = 0;
    while (!s_axi_bvalid && n < 50)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      n++;
    end
    check(s_axi_bresp, (a == 5'h1c) ? 2'h2 : 2'h0);
    s_axi_bready <= 1;
    @(posedge aclk);
    s_axi_bready <= 0;
    check(n < 50, 1);
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    n = 0;
    while (!s_axi_rvalid && n < 50)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      n++;
    end
    s_axi_rready <= 1;
    @(posedge aclk);
    s_axi_rready <= 0;
    check(s_axi_rdata, e);
    check(s_axi_rresp, er);
  endtask
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rc(5'h00, 0, 0);
    rc(5'h04, 0, 0);
    rc(5'h08, 0, 0);
    rc(5'h1c, 0, 2'h2);
    seed = 17'h1_81c3;
    wr(5'h04, {24'h00_0000, seed[7:0]}, 4'h1);
    rc(5'h04, seed[7:0], 0);
    for (int m = 0; m < 8; m++)
    begin
      seed = lfsr(seed);
      sync = m[2];
      wide = m[1];
      hs = m[0];
      hi = seed[0] + 1;
      lo = seed[11:8];
      wr(5'h0c, {sync[0], 1'h0, hs[0], 2'h0}, 4'h1);
      wr(5'h08, {wide[0], 3'h0}, 4'h1);
      if (m[0])
      begin
        wr(5'h00, lo, 4'h1);
        wr(5'h04, hi, 4'h1);
      end
      else
      begin
        wr(5'h04, hi, 4'h1);
        wr(5'h00, lo, 4'h1);
      end
      per = pre() * ((wide ? hi * 256 + lo : lo) + 1);
      repeat (2)
      begin
        k = 1;
        @(posedge aclk);
        while (!baud_tick && k < 20000)
        begin
          @(posedge aclk);
          k++;
        end
        check(k, per);
      end
      rc(5'h10, (pre() << 16) | (wide ? hi * 256 + lo : lo), 0);
      rc(5'h0c, {sync[0], 1'h0, hs[0], 2'h0}, 0);
    end
    wr(5'h00, 32'h0000_00ff, 4'h0);
    rc(5'h00, lo, 0);
    wr(5'h1c, 32'h0000_0001, 4'h1);
    test_done();
  end
  initial
  begin
    #1_000_000;
    fail_count++;
    test_done();
  end
endmodule // tb
